// ===== bench/ppg_host.sv
`timescale 1ns/1ns
`default_nettype none
module ppg_host
(
    input  wire logic       clk_in,   // Clock
    input  wire logic [7:0] rdata_in, // Read data
    output var  logic       wr_out,   // Write strobe
    output var  logic       rd_out,   // Read strobe
    output var  logic [7:0] addr_out, // Address
    output var  logic [7:0] wdata_out // Write data
);
    // ****************************************
    // Register access, entered at a rising edge
    // ****************************************
    initial
    begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // Strobe left up so a following access may run back to back
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        #1;
        rd_out = 1'b0;
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
        @(posedge clk_in);
    endtask
    // Released data shows a changed value, never the last one
    task automatic idle();
        #1;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = ~wdata_out;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== bench/ppg_pwm_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ppg_pwm_chk
(
    input wire logic       clk_in,               // Clock
    input wire logic       srst_in,              // Sync reset
    input wire logic       ce_in,                // Clock enable
    input wire logic       wr_in,                // Write strobe
    input wire logic       rd_in,                // Read strobe
    input wire logic [7:0] addr_in,              // Address
    input wire logic [7:0] wdata_in,             // Write data
    input wire logic [7:0] rdata_out,            // Read data
    input wire logic [9:0] sink_channel_pin_out, // Sink pins
    input wire logic       period_start_out      // Period wrap
);
    // ****************************************
    // Enable shadow and properties
    // ****************************************
    logic [9:0] en_sh;
    logic [9:0] en_d1;
    logic [9:0] en_d2;
    logic [9:0] next_en;
    // Shadow of enables, two old copies absorb pipeline lag
    always_comb
    begin
        next_en = en_sh;
        if (ce_in && wr_in && addr_in == ppg_pkg::ADDR_EN_LO)
            next_en[7:0] = wdata_in;
        if (ce_in && wr_in && addr_in == ppg_pkg::ADDR_EN_HI)
            next_en[9:8] = wdata_in[1:0];
    end
    always_ff @(posedge clk_in)
    begin
        en_sh <= srst_in ? 10'h000 : next_en;
        if (ce_in || srst_in)
        begin
            en_d1 <= en_sh;
            en_d2 <= en_d1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    rst_outs_a: assert property ($fell(srst_in) |->
        sink_channel_pin_out == 10'h000 && rdata_out == 8'h00) else $error("outputs after reset");
    rd_hold_a: assert property (!(ce_in && rd_in) |=> $stable(rdata_out))
        else $error("read data moved");
    unmapped_rd_a: assert property (ce_in && rd_in && addr_in > 8'h25 |=> rdata_out == 8'h00)
        else $error("unmapped read");
    grp_hi_a: assert property (ce_in && rd_in && (addr_in == 8'h01 || addr_in == 8'h09)
        |=> rdata_out[7:2] == 6'h00) else $error("high byte spare bits");
    per_hi_a: assert property (ce_in && rd_in && addr_in == 8'h25
        |=> rdata_out[7:5] == 3'h0) else $error("period spare bits");
    wr_rd_a: assert property (ce_in && wr_in && addr_in == 8'h00 ##1
        ce_in && rd_in && !wr_in && addr_in == 8'h00 |=> rdata_out == $past(wdata_in, 2))
        else $error("enable read back");
    freeze_a: assert property (!ce_in |=> $stable(sink_channel_pin_out)
        && $stable(period_start_out)) else $error("moved while frozen");
    wrap_pulse_a: assert property (ce_in && period_start_out |=> !period_start_out [*8])
        else $error("period pulse too long");
    en_gate_a: assert property ((sink_channel_pin_out & ~(en_sh | en_d1 | en_d2))
        == 10'h000) else $error("disabled sink on");
endmodule
bind ppg_pwm ppg_pwm_chk ppg_pwm_chk_inst (.clk_in, .srst_in, .ce_in, .wr_in, .rd_in,
    .addr_in, .wdata_in, .rdata_out, .sink_channel_pin_out, .period_start_out);
`default_nettype wire

// ===== bench/tb_ppg_pwm.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ppg_pwm;
    // ****************************************
    // Bench
    // ****************************************
    logic       clk_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       ce_in = 1'b1;
    wire logic       wr, rd, ps;
    wire logic [7:0] addr, wdata, rdata;
    wire logic [9:0] pins;
    int         error_cnt = 0;
    int         n_checks = 0;
    always #5 clk_in = ~clk_in;
    ppg_pwm ppg_pwm_inst (.clk_in, .srst_in, .ce_in, .wr_in(wr), .rd_in(rd), .addr_in(addr),
        .wdata_in(wdata), .rdata_out(rdata), .sink_channel_pin_out(pins), .period_start_out(ps));
    ppg_host ppg_host_inst (.clk_in, .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
        .addr_out(addr), .wdata_out(wdata));
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_regs();
        logic [7:0] a [9] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h10, 8'h11, 8'h24, 8'h25, 8'h30};
        logic [7:0] m [9] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 9; i++)
        begin
            ppg_host_inst.rd_reg(a[i], d);
            chk(d === 8'h00, "reset value");
            ppg_host_inst.wr_reg(a[i], 8'hFF);
            ppg_host_inst.rd_reg(a[i], d);
            chk(d === m[i], "read back");
        end
    endtask
    // Period N=9 gives ten slots 150 cycles apart; channel 0 overlaps slot 1
    task automatic setup();
        ppg_host_inst.wr_reg(8'h24, 8'h09);
        ppg_host_inst.wr_reg(8'h25, 8'h00);
        for (int k = 0; k < 10; k++)
        begin
            ppg_host_inst.wr_reg(8'h10 + 8'(2 * k), (k == 0) ? 8'h14 : 8'(k));
            ppg_host_inst.wr_reg(8'h11 + 8'(2 * k), 8'h00);
        end
        ppg_host_inst.idle();
        #1 ce_in = 1'b0;
        repeat (5) @(posedge clk_in);
        #1 ce_in = 1'b1;
        @(posedge clk_in);
    endtask
    task automatic sync();
        int n;
        @(negedge clk_in);
        for (n = 0; n < 1600 && ps !== 1'b1; n++)
            @(negedge clk_in);
        chk(n < 1600, "no period wrap");
    endtask
    task automatic run_case(input logic [9:0] en, input logic [9:0] grp);
        int rise[10], hi[10], n, ld, w;
        logic [9:0] prev;
        ppg_host_inst.wr_reg(8'h00, en[7:0]);
        ppg_host_inst.wr_reg(8'h01, {6'h00, en[9:8]});
        ppg_host_inst.wr_reg(8'h08, grp[7:0]);
        ppg_host_inst.wr_reg(8'h09, {6'h00, grp[9:8]});
        ppg_host_inst.idle();
        sync();
        sync();
        prev = 10'h000;
        rise = '{default: -1};
        hi = '{default: 0};
        for (n = 0; n < 1600; n++)
        begin
            for (int k = 0; k < 10; k++)
            begin
                if (pins[k] === 1'b1 && prev[k] !== 1'b1 && rise[k] < 0)
                    rise[k] = n;
                if (pins[k] === 1'b1)
                    hi[k]++;
            end
            prev = pins;
            @(negedge clk_in);
            if (ps === 1'b1)
                break;
        end
        chk(n == 10 * ppg_pkg::PER_STEP_CYC - 1, "period length");
        for (int k = 0; k < 10; k++)
        begin
            ld = k;
            while (ld > 0 && grp[ld])
                ld--;
            w = (en[ld] && en[k]) ? ((ld == 0) ? 20 : ld) * ppg_pkg::ONT_STEP_CYC : 0;
            chk(hi[k] == w, "on-time");
            if (w > 0)
                chk(rise[k] - rise[0] == ld * ppg_pkg::PER_STEP_CYC, "slot");
        end
        @(posedge clk_in);
    endtask
    task automatic test_ungrouped();
        setup();
        run_case(10'h3FF, 10'h000);
    endtask
    task automatic test_grouped();
        run_case(10'h3FF, 10'h01B);
    endtask
    task automatic test_leader_off();
        run_case(10'h3FB, 10'h01B);
    endtask
    task automatic test_member_off();
        run_case(10'h3EF, 10'h01B);
    endtask
    initial
    begin
        repeat (40000) @(posedge clk_in);
        error_cnt++;
        $display("unexpected at %0t: timeout", $time);
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge clk_in);
        #1 srst_in = 1'b0;
        @(posedge clk_in);
        test_regs();
        test_ungrouped();
        test_grouped();
        test_leader_off();
        test_member_off();
        stop_test();
    end
endmodule
`default_nettype wire

// ===== common/ppg_pkg.sv
// Notes on behaviour
// RL1 - Ungrouped channels each start in own slot
// RL2 - Per-channel enable bit and on-time register
// RL3 - Enabled channel on from slot start for on-time
// RL4 - Groups only join adjacent channels, two or more
// RL5 - Grouping bits at 0x08/0x09 form groups
// RL6 - Grouped channel uses lower neighbour slot and on-time
// RL7 - Slot of grouped channel stays empty
// RL8 - Whole group follows lowest member slot, on-time
// RL9 - First member disabled disables whole group
// RL10 - Other member disabled affects only itself
// RL11 - Slots sequential, periodic, unused slots kept
// RL12 - Pulses may overlap later slots
// RL13 - Current setting stays per channel
// RL14 - Period is (N+1) times 1.5 us, live update
// RL15 - On-time is 16-bit, 0.15 us steps
// RL16 - Slot k starts at k/10 of period
`default_nettype none
package ppg_pkg;
    localparam int          NUM_CH          = 10;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  ADDR_EN_LO      = 8'h00;
    localparam logic [7:0]  ADDR_EN_HI      = 8'h01;
    localparam logic [7:0]  ADDR_GRP_LO     = 8'h08;
    localparam logic [7:0]  ADDR_GRP_HI     = 8'h09;
    localparam logic [7:0]  ADDR_ONT_FIRST  = 8'h10;
    localparam logic [7:0]  ADDR_ONT_LAST   = 8'h23;
    localparam logic [7:0]  ADDR_PER_LO     = 8'h24;
    localparam logic [7:0]  ADDR_PER_HI     = 8'h25;
    localparam logic [9:0]  EN_RESET        = 10'h000;
    localparam logic [9:0]  GRP_RESET       = 10'h000;
    localparam logic [15:0] ONT_RESET       = 16'h0000;
    localparam logic [12:0] PER_RESET       = 13'h0000;
    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_PS   = 10000;
    localparam int          PER_STEP_PS     = 1500000;
    localparam int          ONT_STEP_PS     = 150000;
    localparam int          PER_STEP_CYC    = PER_STEP_PS / CLK_PERIOD_PS;
    localparam int          ONT_STEP_CYC    = ONT_STEP_PS / CLK_PERIOD_PS;
endpackage
`default_nettype wire

// ===== logic/ppg_pwm.sv
`timescale 1ns/1ns
`default_nettype none
module ppg_pwm
(
    input  wire logic       clk_in,      // 100 MHz clock
    input  wire logic       srst_in,     // Sync reset, high
    input  wire logic       ce_in,       // Clock enable
    input  wire logic       wr_in,       // Register write strobe
    input  wire logic       rd_in,       // Register read strobe
    input  wire logic [7:0] addr_in,     // Register address
    input  wire logic [7:0] wdata_in,    // Write data
    output var  logic [7:0] rdata_out,   // Read data, valid after rd
    output var  logic [9:0] sink_channel_pin_out, // Sink on, per channel
    output var  logic       period_start_out      // Pulse at period start
);
    localparam int NC = ppg_pkg::NUM_CH;

    // ****************************************
    // Registers
    // ****************************************
    logic [9:0]  en, next_en;
    logic [9:0]  grp, next_grp;
    logic [15:0] ont [NC];
    logic [15:0] next_ont [NC];
    logic [12:0] per, next_per;
    logic [7:0]  next_rdata;

    // Write decode; byte 0 of a pair is the low byte
    always_comb
    begin
        next_en  = en;
        next_grp = grp;
        next_per = per;
        for (int i = 0; i < NC; i++)
        begin
            next_ont[i] = ont[i];
        end
        if (wr_in)
        begin
            case (addr_in)
                ppg_pkg::ADDR_EN_LO:  next_en[7:0]   = wdata_in;          // RL2
                ppg_pkg::ADDR_EN_HI:  next_en[9:8]   = wdata_in[1:0];     // RL2
                ppg_pkg::ADDR_GRP_LO: next_grp[7:0]  = wdata_in;          // RL5
                ppg_pkg::ADDR_GRP_HI: next_grp[9:8]  = wdata_in[1:0];     // RL5
                ppg_pkg::ADDR_PER_LO: next_per[7:0]  = wdata_in;          // RL14
                ppg_pkg::ADDR_PER_HI: next_per[12:8] = wdata_in[4:0];     // RL14
                default:
                begin
                    for (int i = 0; i < NC; i++)
                    begin
                        if (addr_in == ppg_pkg::ADDR_ONT_FIRST + 8'(2 * i))
                            next_ont[i][7:0] = wdata_in;                 // RL2 RL15
                        if (addr_in == ppg_pkg::ADDR_ONT_FIRST + 8'(2 * i + 1))
                            next_ont[i][15:8] = wdata_in;                // RL15
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = rdata_out;
        if (rd_in)
        begin
            case (addr_in)
                ppg_pkg::ADDR_EN_LO:  next_rdata = en[7:0];
                ppg_pkg::ADDR_EN_HI:  next_rdata = {6'h00, en[9:8]};
                ppg_pkg::ADDR_GRP_LO: next_rdata = grp[7:0];
                ppg_pkg::ADDR_GRP_HI: next_rdata = {6'h00, grp[9:8]};
                ppg_pkg::ADDR_PER_LO: next_rdata = per[7:0];
                ppg_pkg::ADDR_PER_HI: next_rdata = {3'h0, per[12:8]};
                default:
                begin
                    next_rdata = 8'h00;
                    for (int i = 0; i < NC; i++)
                    begin
                        if (addr_in == ppg_pkg::ADDR_ONT_FIRST + 8'(2 * i))
                            next_rdata = ont[i][7:0];
                        if (addr_in == ppg_pkg::ADDR_ONT_FIRST + 8'(2 * i + 1))
                            next_rdata = ont[i][15:8];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            en        <= ppg_pkg::EN_RESET;
            grp       <= ppg_pkg::GRP_RESET;
            per       <= ppg_pkg::PER_RESET;
            rdata_out <= 8'h00;
            for (int i = 0; i < NC; i++)
            begin
                ont[i] <= ppg_pkg::ONT_RESET;
            end
        end
        else if (ce_in)
        begin
            en        <= next_en;
            grp       <= next_grp;
            per       <= next_per;
            rdata_out <= next_rdata;
            for (int i = 0; i < NC; i++)
            begin
                ont[i] <= next_ont[i];
            end
        end
    end

    // ****************************************
    // Group resolution
    // ****************************************
    // Grouping bit i joins channel i to channel i-1; bit 0 has no lower
    // neighbour and is ignored, so a group always has two or more members.
    logic [3:0] leader [NC];
    always_comb
    begin
        leader[0] = 4'h0;
        for (int i = 1; i < NC; i++)
        begin
            leader[i] = grp[i] ? leader[i-1] : 4'(i);                   // RL4 RL6 RL8
        end
    end

    // ****************************************
    // Period and slot timing
    // ****************************************
    // Period length in 10 ns ticks; 1.5 us step = 150 cycles.
    // Slot k start = k * period / 10, taken by ten fixed fractions.
    logic [7:0]  tick, next_tick;          // Counts within a tenth of a 1.5 us step
    logic [12:0] step, next_step;          // Steps within the period
    logic [3:0]  tenth, next_tenth;        // Sub-position 0..9 within a step
    logic [12:0] slot_step [NC];
    logic [3:0]  slot_tenth [NC];
    logic [15:0] left [NC];                // On-time cycles left, in 0.15 us units
    logic [15:0] next_left [NC];
    logic [3:0]  sub [NC];                 // Cycles within a 0.15 us unit
    logic [3:0]  next_sub [NC];
    logic [9:0]  next_pin;
    logic        next_pstart;
    logic        wrap;

    // Slot start of channel k: offset = k*(N+1)*150/10 cycles = k*(N+1)*15
    // expressed as whole steps plus tenths of a step.
    always_comb
    begin
        for (int k = 0; k < NC; k++)
        begin
            slot_step[k]  = 13'((k * (32'(per) + 1)) / NC);             // RL16
            slot_tenth[k] = 4'((k * (32'(per) + 1)) % NC);              // RL16
        end
    end

    always_comb
    begin
        next_tick  = tick;
        next_step  = step;
        next_tenth = tenth;
        wrap       = 1'b0;
        // Tenth advances every 15 cycles: ten tenths make one 1.5 us step
        if (tick == 8'(ppg_pkg::PER_STEP_CYC / NC - 1))
        begin
            next_tick = 8'h00;
            if (tenth == 4'(NC - 1))
            begin
                next_tenth = 4'h0;
                if (step >= per)                                        // RL14 RL11
                begin
                    next_step = 13'h0000;
                    wrap      = 1'b1;
                end
                else
                begin
                    next_step = step + 13'h0001;
                end
            end
            else
            begin
                next_tenth = tenth + 4'h1;
            end
        end
        else
        begin
            next_tick = tick + 8'h01;
        end
        next_pstart = wrap;
        // Each slot leader runs its own down-counter, so pulses can overlap
        for (int i = 0; i < NC; i++)
        begin
            next_left[i] = left[i];
            next_sub[i]  = sub[i];
            if (left[i] != 16'h0000)
            begin
                if (sub[i] == 4'(ppg_pkg::ONT_STEP_CYC - 1))
                begin
                    next_sub[i]  = 4'h0;
                    next_left[i] = left[i] - 16'h0001;                  // RL12
                end
                else
                begin
                    next_sub[i] = sub[i] + 4'h1;
                end
            end
            // Only leaders own a slot; grouped slots stay empty
            if (leader[i] == 4'(i) && tick == 8'h00 && step == slot_step[i]
                && tenth == slot_tenth[i])                             // RL1 RL7 RL11
            begin
                next_left[i] = ont[i];                                  // RL3
                next_sub[i]  = 4'h0;
            end
            next_pin[i] = 1'b0;
        end
        for (int i = 0; i < NC; i++)
        begin
            // Member runs on leader's counter; leader enable gates all
            next_pin[i] = (next_left[leader[i]] != 16'h0000)
                          && en[leader[i]] && en[i];                    // RL6 RL9 RL10
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            tick                 <= 8'h00;
            step                 <= 13'h0000;
            tenth                <= 4'h0;
            sink_channel_pin_out <= 10'h000;
            period_start_out     <= 1'b0;
            for (int i = 0; i < NC; i++)
            begin
                left[i] <= 16'h0000;
                sub[i]  <= 4'h0;
            end
        end
        else if (ce_in)
        begin
            tick                 <= next_tick;
            step                 <= next_step;
            tenth                <= next_tenth;
            sink_channel_pin_out <= next_pin;                           // RL13
            period_start_out     <= next_pstart;
            for (int i = 0; i < NC; i++)
            begin
                left[i] <= next_left[i];
                sub[i]  <= next_sub[i];
            end
        end
    end
endmodule
`default_nettype wire
